// ---- include/bttev_pkg.sv ----
/*
 * Constants, register map and carrier types of the battery and thermal trip event block.
 * Assumes a 32-bit AHB-Lite slave port and temperatures in tenths of a kelvin.
 */
`default_nettype none
package bttev_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned TEMP_W = 16;
	localparam int unsigned ADDR_W = 8;

	// ==========================================================================
	// Register byte offsets.
	localparam logic [7:0] OFS_BATT_TRIP     = 8'h00;
	localparam logic [7:0] OFS_POWER_SRC     = 8'h04;
	localparam logic [7:0] OFS_ZONE_TEMP     = 8'h08;
	localparam logic [7:0] OFS_ACTIVE_TRIP   = 8'h0C;
	localparam logic [7:0] OFS_PASSIVE_TRIP  = 8'h10;
	localparam logic [7:0] OFS_CRITICAL_TRIP = 8'h14;
	localparam logic [7:0] OFS_COOL_POLICY   = 8'h18;
	localparam logic [7:0] OFS_PRESET_ACT    = 8'h1C;
	localparam logic [7:0] OFS_PRESET_PAS    = 8'h20;
	localparam logic [7:0] OFS_BAY_ADJUST    = 8'h24;
	localparam logic [7:0] OFS_HYST_DELTA    = 8'h28;
	localparam logic [7:0] OFS_TEMP_STEP     = 8'h2C;
	localparam logic [7:0] OFS_STATUS        = 8'h30;
	localparam logic [7:0] OFS_MASK          = 8'h34;
	localparam logic [7:0] OFS_NOTIFY_CODE   = 8'h38;

	// ==========================================================================
	// Status and mask bit positions.
	localparam int unsigned ST_CAPACITY = 0;
	localparam int unsigned ST_THERMAL  = 1;
	localparam int unsigned ST_NOTIFY   = 2;
	localparam int unsigned ST_BAY      = 3;
	localparam int unsigned ST_POWER    = 4;
	localparam int unsigned ST_W        = 5;

	// ==========================================================================
	// Codes and reset values.
	localparam logic [7:0]        NOTIFY_THRESH_CHANGED = 8'h80;
	localparam logic [DATA_W-1:0] POWER_OFFLINE         = 32'h00000000;
	localparam logic [DATA_W-1:0] POWER_ONLINE          = 32'h00000001;
	localparam logic [30:0]       RST_BATT_TRIP         = 31'h00000000;
	localparam logic [TEMP_W-1:0] RST_ACTIVE_TRIP       = 16'h0D0C;
	localparam logic [TEMP_W-1:0] RST_PASSIVE_TRIP      = 16'h0D70;
	localparam logic [TEMP_W-1:0] RST_CRITICAL_TRIP     = 16'h0E38;
	localparam logic [TEMP_W-1:0] RST_ADJUST            = 16'h0000;
	localparam logic [ST_W-1:0]   RST_MASK              = 5'h00;
	localparam logic              POLICY_ACTIVE         = 1'b0;
	localparam logic              POLICY_PASSIVE        = 1'b1;

	// ==========================================================================
	// Carrier types.
	typedef struct packed {
		logic [TEMP_W-1:0] passive;
		logic [TEMP_W-1:0] active;
	} bttev_pair_s;

	typedef struct packed {
		logic [TEMP_W-1:0] critical;
		logic [TEMP_W-1:0] passive;
		logic [TEMP_W-1:0] active;
	} bttev_trips_s;

	typedef enum logic {
		HYS_IDLE,
		HYS_LOWERED
	} bttev_hyst_e;

endpackage

`default_nettype wire

// ---- verilog/bttev_top.sv ----
/*
 * Battery capacity trip, line power state and thermal trip events behind an AHB-Lite slave.
 * Assumes all sensor inputs are synchronous to clk and the slave is alone on the bus.
 */
`timescale 1ns/100ps
`default_nettype none

module bttev_top (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           hsel,
	input  wire logic [bttev_pkg::DATA_W-1:0]   haddr,
	input  wire logic [1:0]                     htrans,
	input  wire logic                           hwrite,
	input  wire logic [2:0]                     hsize,
	input  wire logic [bttev_pkg::DATA_W-1:0]   hwdata,
	input  wire logic                           hready,
	output logic      [bttev_pkg::DATA_W-1:0]   hrdata,
	output logic                                hreadyout,
	output logic                                hresp,
	input  wire logic [bttev_pkg::DATA_W-1:0]   battery_remaining_capacity,
	input  wire logic                           line_power_online,
	input  wire logic [bttev_pkg::TEMP_W-1:0]   zone_temperature,
	input  wire logic                           bay_occupied,
	output logic                                system_control_interrupt
);

	// ==========================================================================
	// Bus slave.
	logic                               wr_pend_reg;
	logic [bttev_pkg::ADDR_W-1:0]       wr_addr_reg;
	logic [bttev_pkg::DATA_W-1:0]       hrdata_reg;
	logic                               addr_fire;
	logic                               rd_fire;
	logic [bttev_pkg::ADDR_W-1:0]       a_ofs;
	logic [bttev_pkg::DATA_W-1:0]       rd_val;

	logic [30:0]                        battery_trip_level_reg;
	bttev_pkg::bttev_trips_s            trips_reg;
	logic                               cooling_policy_select_reg;
	bttev_pkg::bttev_pair_s             preset_act_reg;
	bttev_pkg::bttev_pair_s             preset_pas_reg;
	bttev_pkg::bttev_pair_s             bay_adjust_reg;
	logic [bttev_pkg::TEMP_W-1:0]       hyst_delta_reg;
	logic [bttev_pkg::TEMP_W-1:0]       temp_step_reg;
	logic [bttev_pkg::ST_W-1:0]         status_reg;
	logic [bttev_pkg::ST_W-1:0]         status_next;
	logic [bttev_pkg::ST_W-1:0]         mask_reg;

	assign addr_fire = hsel && htrans[1] && hready;
	assign rd_fire   = addr_fire && !hwrite;
	assign a_ofs     = haddr[bttev_pkg::ADDR_W-1:0];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end else begin
			wr_pend_reg <= addr_fire && hwrite;
			wr_addr_reg <= a_ofs;
		end
	end

	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = wr_pend_reg && (wr_addr_reg == ofs);
	endfunction

	always_comb begin
		rd_val = '0;
		case (a_ofs)
			bttev_pkg::OFS_BATT_TRIP:     rd_val = {1'b0, battery_trip_level_reg};
			bttev_pkg::OFS_POWER_SRC:     rd_val = line_power_online ? bttev_pkg::POWER_ONLINE
			                                                         : bttev_pkg::POWER_OFFLINE;
			bttev_pkg::OFS_ZONE_TEMP:     rd_val = {16'h0000, zone_temperature};
			bttev_pkg::OFS_ACTIVE_TRIP:   rd_val = {16'h0000, trips_reg.active};
			bttev_pkg::OFS_PASSIVE_TRIP:  rd_val = {16'h0000, trips_reg.passive};
			bttev_pkg::OFS_CRITICAL_TRIP: rd_val = {16'h0000, trips_reg.critical};
			bttev_pkg::OFS_COOL_POLICY:   rd_val = {31'h00000000, cooling_policy_select_reg};
			bttev_pkg::OFS_PRESET_ACT:    rd_val = preset_act_reg;
			bttev_pkg::OFS_PRESET_PAS:    rd_val = preset_pas_reg;
			bttev_pkg::OFS_BAY_ADJUST:    rd_val = bay_adjust_reg;
			bttev_pkg::OFS_HYST_DELTA:    rd_val = {16'h0000, hyst_delta_reg};
			bttev_pkg::OFS_TEMP_STEP:     rd_val = {16'h0000, temp_step_reg};
			bttev_pkg::OFS_STATUS:        rd_val = {27'h0000000, status_reg};
			bttev_pkg::OFS_MASK:          rd_val = {27'h0000000, mask_reg};
			bttev_pkg::OFS_NOTIFY_CODE:   rd_val = status_reg[bttev_pkg::ST_NOTIFY]
			                              ? {24'h000000, bttev_pkg::NOTIFY_THRESH_CHANGED}
			                              : 32'h00000000;
			default:                      rd_val = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_reg <= '0;
		end else if (rd_fire) begin
			hrdata_reg <= rd_val;
		end
	end

	// ==========================================================================
	// Software configuration registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			battery_trip_level_reg    <= bttev_pkg::RST_BATT_TRIP;
			cooling_policy_select_reg <= bttev_pkg::POLICY_ACTIVE;
			preset_act_reg            <= {bttev_pkg::RST_PASSIVE_TRIP, bttev_pkg::RST_ACTIVE_TRIP};
			preset_pas_reg            <= {bttev_pkg::RST_PASSIVE_TRIP, bttev_pkg::RST_ACTIVE_TRIP};
			bay_adjust_reg            <= {bttev_pkg::RST_ADJUST, bttev_pkg::RST_ADJUST};
			hyst_delta_reg            <= bttev_pkg::RST_ADJUST;
			temp_step_reg             <= bttev_pkg::RST_ADJUST;
			mask_reg                  <= bttev_pkg::RST_MASK;
		end else begin
			if (wr_hit(bttev_pkg::OFS_BATT_TRIP)) begin
				battery_trip_level_reg <= hwdata[30:0];
			end
			if (wr_hit(bttev_pkg::OFS_COOL_POLICY)) begin
				cooling_policy_select_reg <= hwdata[0];
			end
			if (wr_hit(bttev_pkg::OFS_PRESET_ACT)) begin
				preset_act_reg <= hwdata;
			end
			if (wr_hit(bttev_pkg::OFS_PRESET_PAS)) begin
				preset_pas_reg <= hwdata;
			end
			if (wr_hit(bttev_pkg::OFS_BAY_ADJUST)) begin
				bay_adjust_reg <= hwdata;
			end
			if (wr_hit(bttev_pkg::OFS_HYST_DELTA)) begin
				hyst_delta_reg <= hwdata[15:0];
			end
			if (wr_hit(bttev_pkg::OFS_TEMP_STEP)) begin
				temp_step_reg <= hwdata[15:0];
			end
			if (wr_hit(bttev_pkg::OFS_MASK)) begin
				mask_reg <= hwdata[bttev_pkg::ST_W-1:0];
			end
		end
	end

	// ==========================================================================
	// Battery capacity trip.
	logic cap_below;
	logic cap_below_reg;
	logic cap_event;

	assign cap_below = !battery_remaining_capacity[31] && (battery_trip_level_reg != 31'h00000000)
	                && (battery_remaining_capacity[30:0] <= battery_trip_level_reg);
	assign cap_event = cap_below && !cap_below_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_below_reg <= 1'b0;
		end else begin
			cap_below_reg <= cap_below;
		end
	end

	// ==========================================================================
	// Threshold reload, bay detection and hysteresis.
	function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
		sat_sub = (a > b) ? (a - b) : 16'h0000;
	endfunction

	logic                         bay_reg;
	logic                         bay_edge;
	logic                         policy_wr;
	logic                         reload;
	bttev_pkg::bttev_pair_s       preset_sel;
	bttev_pkg::bttev_pair_s       load_val;
	bttev_pkg::bttev_hyst_e       hyst_state;
	logic [15:0]                  saved_active_reg;
	logic                         hyst_lower;
	logic                         hyst_restore;
	logic                         sw_trip_wr;

	assign bay_edge   = bay_occupied != bay_reg;
	assign policy_wr  = wr_hit(bttev_pkg::OFS_COOL_POLICY);
	assign reload     = policy_wr || bay_edge;
	assign preset_sel = (policy_wr ? hwdata[0] : cooling_policy_select_reg)
	                  ? preset_pas_reg : preset_act_reg;
	assign load_val.active  = sat_sub(preset_sel.active, bay_occupied ? bay_adjust_reg.active
	                                                                  : 16'h0000);
	assign load_val.passive = sat_sub(preset_sel.passive, bay_occupied ? bay_adjust_reg.passive
	                                                                   : 16'h0000);
	assign sw_trip_wr   = wr_hit(bttev_pkg::OFS_ACTIVE_TRIP) || wr_hit(bttev_pkg::OFS_PASSIVE_TRIP)
	                   || wr_hit(bttev_pkg::OFS_CRITICAL_TRIP);
	assign hyst_lower   = !reload && !sw_trip_wr && (hyst_state == bttev_pkg::HYS_IDLE)
	                   && (hyst_delta_reg != 16'h0000) && (zone_temperature >= trips_reg.active);
	assign hyst_restore = !reload && !sw_trip_wr && (hyst_state == bttev_pkg::HYS_LOWERED)
	                   && (zone_temperature <= trips_reg.active);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bay_reg <= 1'b0;
		end else begin
			bay_reg <= bay_occupied;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trips_reg        <= {bttev_pkg::RST_CRITICAL_TRIP, bttev_pkg::RST_PASSIVE_TRIP,
			                     bttev_pkg::RST_ACTIVE_TRIP};
			saved_active_reg <= bttev_pkg::RST_ACTIVE_TRIP;
			hyst_state       <= bttev_pkg::HYS_IDLE;
		end else if (sw_trip_wr) begin
			hyst_state <= bttev_pkg::HYS_IDLE;
			if (wr_hit(bttev_pkg::OFS_ACTIVE_TRIP)) begin
				trips_reg.active <= hwdata[15:0];
			end
			if (wr_hit(bttev_pkg::OFS_PASSIVE_TRIP)) begin
				trips_reg.passive <= hwdata[15:0];
			end
			if (wr_hit(bttev_pkg::OFS_CRITICAL_TRIP)) begin
				trips_reg.critical <= hwdata[15:0];
			end
		end else if (reload) begin
			trips_reg.active  <= load_val.active;
			trips_reg.passive <= load_val.passive;
			hyst_state        <= bttev_pkg::HYS_IDLE;
		end else begin
			case (hyst_state)
				bttev_pkg::HYS_IDLE: begin
					if (hyst_lower) begin
						saved_active_reg <= trips_reg.active;
						trips_reg.active <= sat_sub(trips_reg.active, hyst_delta_reg);
						hyst_state       <= bttev_pkg::HYS_LOWERED;
					end
				end
				bttev_pkg::HYS_LOWERED: begin
					if (hyst_restore) begin
						trips_reg.active <= saved_active_reg;
						hyst_state       <= bttev_pkg::HYS_IDLE;
					end
				end
				default: hyst_state <= bttev_pkg::HYS_IDLE;
			endcase
		end
	end

	// ==========================================================================
	// Thermal crossings and temperature steps.
	logic [2:0]  above;
	logic [2:0]  above_reg;
	logic [47:0] thr_flat;
	logic [15:0] last_temp_reg;
	logic        primed_reg;
	logic [15:0] temp_diff;
	logic        step_hit;
	logic        power_reg;

	assign thr_flat = trips_reg;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_cross
			assign above[gi] = zone_temperature >= thr_flat[gi*16 +: 16];
		end
	endgenerate

	assign temp_diff = (zone_temperature > last_temp_reg) ? (zone_temperature - last_temp_reg)
	                                                      : (last_temp_reg - zone_temperature);
	assign step_hit  = primed_reg && (temp_step_reg != 16'h0000) && (temp_diff >= temp_step_reg);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			above_reg     <= 3'h0;
			last_temp_reg <= 16'h0000;
			primed_reg    <= 1'b0;
			power_reg     <= 1'b0;
		end else begin
			above_reg  <= above;
			primed_reg <= 1'b1;
			power_reg  <= line_power_online;
			if (!primed_reg || step_hit) begin
				last_temp_reg <= zone_temperature;
			end
		end
	end

	// ==========================================================================
	// Sticky status and interrupt.
	logic [bttev_pkg::ST_W-1:0] set_vec;
	logic [bttev_pkg::ST_W-1:0] clr_vec;

	always_comb begin
		set_vec = '0;
		set_vec[bttev_pkg::ST_CAPACITY] = cap_event;
		set_vec[bttev_pkg::ST_THERMAL]  = primed_reg && ((above != above_reg) || step_hit);
		set_vec[bttev_pkg::ST_NOTIFY]   = reload || hyst_lower || hyst_restore;
		set_vec[bttev_pkg::ST_BAY]      = bay_edge;
		set_vec[bttev_pkg::ST_POWER]    = primed_reg && (line_power_online != power_reg);
		clr_vec = wr_hit(bttev_pkg::OFS_STATUS) ? hwdata[bttev_pkg::ST_W-1:0] : '0;
		status_next = (status_reg & ~clr_vec) | set_vec;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	assign system_control_interrupt = |(status_reg & mask_reg);

	// ==========================================================================
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_cap_event: assert property (cap_event |=> status_reg[bttev_pkg::ST_CAPACITY])
		else $error("capacity trip not flagged");
	chk_trip_hold: assert property (!wr_hit(bttev_pkg::OFS_BATT_TRIP)
		|=> $stable(battery_trip_level_reg))
		else $error("battery trip level changed without write");
	chk_trip_zero: assert property ((battery_trip_level_reg == 31'h00000000)
		&& !status_reg[bttev_pkg::ST_CAPACITY] |=> !status_reg[bttev_pkg::ST_CAPACITY])
		else $error("capacity event with cleared trip point");
	chk_power_code: assert property (rd_fire && (a_ofs == bttev_pkg::OFS_POWER_SRC)
		|=> hrdata == {31'h00000000, $past(line_power_online)})
		else $error("power source code wrong");
	chk_temp_read: assert property (rd_fire && (a_ofs == bttev_pkg::OFS_ZONE_TEMP)
		|=> hrdata == {16'h0000, $past(zone_temperature)})
		else $error("zone temperature read wrong");
	chk_cross_flag: assert property (primed_reg && (above != above_reg)
		|=> status_reg[bttev_pkg::ST_THERMAL])
		else $error("thermal crossing not flagged");
	chk_step_event: assert property (step_hit
		|=> status_reg[bttev_pkg::ST_THERMAL] && (last_temp_reg == $past(zone_temperature)))
		else $error("temperature step not flagged");
	chk_notify_code: assert property (status_reg[bttev_pkg::ST_NOTIFY] && rd_fire
		&& (a_ofs == bttev_pkg::OFS_NOTIFY_CODE) |=> hrdata == 32'h00000080)
		else $error("notify code not 0x80");
	chk_policy_load: assert property (policy_wr && !sw_trip_wr
		|=> (trips_reg.active == $past(load_val.active)) && status_reg[bttev_pkg::ST_NOTIFY])
		else $error("policy change did not load thresholds");
	chk_bay_notify: assert property (bay_edge
		|=> status_reg[bttev_pkg::ST_BAY] && status_reg[bttev_pkg::ST_NOTIFY])
		else $error("bay change not notified");
	chk_hyst_lower: assert property (hyst_lower
		|=> (trips_reg.active == sat_sub($past(trips_reg.active), $past(hyst_delta_reg)))
		&& status_reg[bttev_pkg::ST_NOTIFY] && (hyst_state == bttev_pkg::HYS_LOWERED))
		else $error("hysteresis lowering wrong");
	chk_sticky_hold: assert property (!wr_hit(bttev_pkg::OFS_STATUS)
		|=> (status_reg & $past(status_reg)) == $past(status_reg))
		else $error("status bit dropped without acknowledge");

	cov_cap_trip: cover property (cap_event ##1 system_control_interrupt);
	cov_policy:   cover property (policy_wr ##1 status_reg[bttev_pkg::ST_NOTIFY]);
	cov_hyst:     cover property (hyst_lower ##[1:50] hyst_restore);
	cov_bay:      cover property (bay_edge ##1 status_reg[bttev_pkg::ST_BAY]);

endmodule

`default_nettype wire

// ---- verif/bttev_host.sv ----
/* Host model: an AHB-Lite master that issues single word transfers for the bench.
 * Assumes one slave whose hreadyout is returned to it as hready. */
`timescale 1ns/100ps
`default_nettype none
module bttev_host (
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	output logic             stuck
);
	initial {hsel, haddr, htrans, hwrite, hsize, hwdata, stuck} = {36'h0, 3'h2, 33'h0};
	// Waits for hready at a rising edge and gives up after 16 edges.
	task automatic wait_rdy();
		for (int n = 0; n < 16; n++) begin
			@(posedge clk);
			if (hready === 1'b1) return;
		end
		stuck = 1'b1;
	endtask
	// Holds each phase until hready is seen high, then takes read data at that edge.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		{hsel, haddr, htrans, hwrite} <= {1'b1, 24'h000000, a, 2'h2, w};
		wait_rdy();
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		wait_rdy();
		q = hrdata;
	endtask
	// Reads the zone temperature and the three trips, then picks the cooling action.
	task automatic policy(output logic [2:0] act);
		logic [31:0] t, a, p, c;
		xfer(1'b0, 8'h08, 32'h0, t);
		xfer(1'b0, 8'h0C, 32'h0, a);
		xfer(1'b0, 8'h10, 32'h0, p);
		xfer(1'b0, 8'h14, 32'h0, c);
		act[0] = t >= a;
		act[1] = t >= p;
		act[2] = t >= c;
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_battery_thermal_trip_events.sv ----
/* Self-checking bench for the battery and thermal trip event block.
 * Assumes bttev_host stands in for the host software on the register bus. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		n_mismatch++; \
		$display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); \
	end \
	end
module tb_battery_thermal_trip_events;
	logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, stuck, lp, bay, irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize, act;
	logic [15:0] temp;
	logic [31:0] haddr, hwdata, hrdata, cap, rd;
	int          n_mismatch = 0;
	int          check_count = 0;
	bttev_top dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .battery_remaining_capacity(cap),
		.line_power_online(lp), .zone_temperature(temp), .bay_occupied(bay),
		.system_control_interrupt(irq));
	bttev_host host_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.stuck(stuck));
	always #25 clk = ~clk;
	task automatic final_report();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// A bus wait that ran out of edges ends the run as a mismatch.
	always @(posedge stuck) begin
		n_mismatch++;
		final_report();
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'b1, a, d, rd);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		host_u.xfer(1'b0, a, 32'h0, rd);
		`CHK(rd, e)
	endtask
	task automatic ichk(input logic e);
		@(negedge clk);
		`CHK(irq, e)
	endtask
	task automatic sc_reset();
		rchk(8'h14, 32'hE38);
		rchk(8'h08, 32'hB00);
		rchk(8'h30, 32'h0);
		rchk(8'h3C, 32'h0);
		`CHK(hresp, 1'b0)
	endtask
	task automatic sc_power();
		@(posedge clk);
		lp <= 1'b1;
		rchk(8'h04, 32'h1);
		rchk(8'h30, 32'h10);
		@(posedge clk);
		lp <= 1'b0;
		wr(8'h30, 32'h10);
		rchk(8'h04, 32'h0);
		rchk(8'h30, 32'h0);
	endtask
	task automatic sc_cap();
		wr(8'h00, 32'h800);
		wr(8'h34, 32'h1);
		rchk(8'h00, 32'h800);
		@(posedge clk);
		cap <= 32'h800;
		rchk(8'h30, 32'h1);
		ichk(1'b1);
		@(posedge clk);
		cap <= 32'h700;
		wr(8'h30, 32'h1);
		ichk(1'b0);
		wr(8'h00, 32'h0);
		@(posedge clk);
		cap <= 32'h10;
		rchk(8'h30, 32'h0);
	endtask
	task automatic sc_therm();
		wr(8'h28, 32'h64);
		@(posedge clk);
		temp <= 16'hD0C;
		rchk(8'h30, 32'h6);
		rchk(8'h0C, 32'hCA8);
		rchk(8'h38, 32'h80);
		host_u.policy(act);
		`CHK(act, 3'h1)
		wr(8'h30, 32'h6);
		@(posedge clk);
		temp <= 16'hCA8;
		rchk(8'h0C, 32'hD0C);
		host_u.policy(act);
		`CHK(act, 3'h0)
		@(posedge clk);
		temp <= 16'hB00;
		wr(8'h30, 32'h1F);
	endtask
	task automatic sc_policy();
		wr(8'h20, 32'h0D000C80);
		wr(8'h18, 32'h1);
		rchk(8'h0C, 32'hC80);
		rchk(8'h10, 32'hD00);
		rchk(8'h30, 32'h4);
		wr(8'h30, 32'h1F);
	endtask
	task automatic sc_bay();
		wr(8'h24, 32'h00100020);
		wr(8'h34, 32'h8);
		@(posedge clk);
		bay <= 1'b1;
		rchk(8'h0C, 32'hC60);
		rchk(8'h10, 32'hCF0);
		rchk(8'h30, 32'hC);
		ichk(1'b1);
		wr(8'h30, 32'hC);
		ichk(1'b0);
	endtask
	task automatic sc_step();
		wr(8'h2C, 32'h32);
		wr(8'h34, 32'h2);
		@(posedge clk);
		temp <= 16'hB20;
		rchk(8'h30, 32'h0);
		@(posedge clk);
		temp <= 16'hB40;
		rchk(8'h30, 32'h2);
		ichk(1'b1);
		wr(8'h30, 32'h2);
		@(posedge clk);
		temp <= 16'hB0E;
		rchk(8'h30, 32'h2);
		wr(8'h30, 32'h2);
		ichk(1'b0);
	endtask
	initial begin
		{clk, rst_n, lp, bay, cap, temp} = {4'h0, 32'h1000, 16'hB00};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		sc_reset();
		sc_power();
		sc_cap();
		sc_therm();
		sc_policy();
		sc_bay();
		sc_step();
		final_report();
	end
endmodule
`default_nettype wire
